// *** verilog/safety_diag_defs.vh ***
// constants for the safety sensor diagnostic block
`ifndef SAFETY_DIAG_DEFS_VH
`define SAFETY_DIAG_DEFS_VH

// timebase
`define CLK_HZ 250000000
`define FLASH_HZ 1
`define HALF_1HZ_CYC (`CLK_HZ / (2 * `FLASH_HZ))
`define PULSE_MS 200
`define PULSE_CYC ((`CLK_HZ / 1000) * `PULSE_MS)
`define PAUSE_MS 1000
`define PAUSE_CYC ((`CLK_HZ / 1000) * `PAUSE_MS)
`define WARN_MIN 30
`define WARN_CYC (40'd250000000 * 40'd60 * `WARN_MIN)

// chain
`define MAX_CHAIN 31

// register byte offsets
`define OFS_CTRL 12'h000
`define OFS_CHAIN 12'h004
`define OFS_RESP 12'h008
`define OFS_WARN 12'h00C
`define OFS_ERR 12'h010
`define OFS_STAT 12'h014

// request byte field
`define CTRL_ERR_RST 7
`define CTRL_RST_VAL 8'h00
`define CHAIN_RST_VAL 5'h00

// response byte fields
`define RSP_SAFE 0
`define RSP_ACT 1
`define RSP_INOK 4
`define RSP_LIMIT 5
`define RSP_WARN 6
`define RSP_ERR 7

// diagnostic byte fields
`define DG_OUT_A 0
`define DG_OUT_B 1
`define DG_CROSS 2
`define DG_TEMP 3
`define DG_ACTR 4
`define DG_INTERNAL 5
`define DG_COMM 6

// red flash codes
`define CODE_NONE 3'h0
`define CODE_STEADY 3'h6

`endif

// *** verilog/flash_gen.v ***
// yellow 1 Hz blinker and red pulse-group generator
`include "safety_diag_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module flash_gen #(
  parameter [31:0] HALF_CYC = `HALF_1HZ_CYC,
  parameter [31:0] PULSE_CYC = `PULSE_CYC,
  parameter [31:0] PAUSE_CYC = `PAUSE_CYC
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // code in, patterns out
  input wire [2:0] code,
  output reg blink,
  output reg red_on
);
  localparam [2:0] S_ON = 3'b001;
  localparam [2:0] S_OFF = 3'b010;
  localparam [2:0] S_PAUSE = 3'b100;

  reg [31:0] bcnt_r;
  reg [31:0] rcnt_r;
  reg [2:0] state_r;
  reg [2:0] npulse_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_r <= 32'h0;
      blink <= 1'b0;
    end else if (bcnt_r >= HALF_CYC - 32'h1) begin
      bcnt_r <= 32'h0;
      blink <= ~blink;
    end else begin
      bcnt_r <= bcnt_r + 32'h1;
    end
  end

  // RULE19 groups then long pause
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= S_PAUSE;
      rcnt_r <= 32'h0;
      npulse_r <= 3'h0;
      red_on <= 1'b0;
    end else if (code == `CODE_NONE) begin
      state_r <= S_PAUSE;
      rcnt_r <= 32'h0;
      npulse_r <= 3'h0;
      red_on <= 1'b0;
    end else if (code == `CODE_STEADY) begin
      state_r <= S_PAUSE;
      rcnt_r <= 32'h0;
      npulse_r <= 3'h0;
      red_on <= 1'b1;
    end else begin
      rcnt_r <= rcnt_r + 32'h1;
      case (state_r)
        S_ON: begin
          red_on <= 1'b1;
          if (rcnt_r >= PULSE_CYC - 32'h1) begin
            rcnt_r <= 32'h0;
            red_on <= 1'b0;
            npulse_r <= npulse_r + 3'h1;
            state_r <= S_OFF;
          end
        end
        S_OFF: begin
          red_on <= 1'b0;
          if (rcnt_r >= PULSE_CYC - 32'h1) begin
            rcnt_r <= 32'h0;
            if (npulse_r >= code) begin
              state_r <= S_PAUSE;
            end else begin
              red_on <= 1'b1;
              state_r <= S_ON;
            end
          end
        end
        S_PAUSE: begin
          red_on <= 1'b0;
          if (rcnt_r >= PAUSE_CYC - 32'h1) begin
            rcnt_r <= 32'h0;
            npulse_r <= 3'h0;
            red_on <= 1'b1;
            state_r <= S_ON;
          end
        end
        default: begin
          state_r <= S_PAUSE;
          red_on <= 1'b0;
        end
      endcase
    end
  end
endmodule // flash_gen
`default_nettype wire

// *** verilog/safety_diag.v ***
// fault handling, indicators and diagnostic bytes of the safety sensor
//
// How it works
// RULE1 - ready and idle: green, outputs low
// RULE2 - actuator present: yellow steady, outputs high
// RULE3 - limit area: yellow 1Hz, outputs on
// RULE4 - limit area pulses the diagnostic output
// RULE5 - red pulse groups encode the fault cause
// RULE6 - any fault forces diagnostic output low
// RULE7 - warning keeps outputs, shutdown after 30min
// RULE8 - warning clears itself when cause gone
// RULE9 - failure drops outputs at once, red flashes
// RULE10 - failure clears: cause gone plus reset/opening
// RULE11 - output failures stay until next release
// RULE12 - link loss freezes safety output state
// RULE13 - at most 31 sensors, diagnostics chained
// RULE14 - response and diagnostic bytes always provided
// RULE15 - controller sends one request byte each
// RULE16 - diag low, outputs on means warning
// RULE17 - status bits are active high
// RULE18 - requests in, responses and diagnostics out
// RULE19 - pause between groups longer than spacing
// RULE20 - warning timer restarts for each warning
`include "safety_diag_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module safety_diag #(
  parameter [39:0] WARN_CYC = `WARN_CYC,
  parameter [31:0] HALF_CYC = `HALF_1HZ_CYC,
  parameter [31:0] PULSE_CYC = `PULSE_CYC,
  parameter [31:0] PAUSE_CYC = `PAUSE_CYC
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // sensor state pins
  input wire sensor_ready,
  input wire act_present,
  input wire act_limit,
  input wire inputs_ok,
  input wire [5:0] warn_cause,
  input wire [5:0] fail_cause,
  input wire comm_err,
  input wire serial_diag_in,
  // indicators and outputs
  output reg led_green,
  output reg led_yellow,
  output reg led_red,
  output reg diag_out,
  output reg safety_out_a,
  output reg safety_out_b,
  // bytes towards the gateway
  output reg [7:0] resp_byte,
  output reg [7:0] warn_byte,
  output reg [7:0] err_byte
);
  // pin synchronisers, 18 bits
  wire [17:0] pins_w;
  reg [17:0] sync1_r;
  reg [17:0] sync2_r;
  assign pins_w = {serial_diag_in, comm_err, fail_cause, warn_cause,
                   inputs_ok, act_limit, act_present, sensor_ready};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 18'h0;
      sync2_r <= 18'h0;
    end else begin
      sync1_r <= pins_w;
      sync2_r <= sync1_r;
    end
  end

  wire ready_s = sync2_r[0];
  wire act_s = sync2_r[1];
  wire limit_s = sync2_r[2];
  wire inok_s = sync2_r[3];
  wire [5:0] warn_s = sync2_r[9:4];
  wire [5:0] fail_s = sync2_r[15:10];
  wire comm_s = sync2_r[16];
  wire chain_s = sync2_r[17];

  // register file
  reg [7:0] ctrl_r;
  reg [4:0] chain_r;
  reg [7:0] ctrl_prev_r;
  reg wr_pend_r;
  reg [11:0] wr_addr_r;

  wire req_w = hsel & hready & htrans[1];

  // flash pattern generator
  wire blink_w;
  wire red_pat_w;
  reg [2:0] code_w;

  flash_gen #(
    .HALF_CYC(HALF_CYC),
    .PULSE_CYC(PULSE_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) u_flash (
    .hclk(hclk),
    .hresetn(hresetn),
    .code(code_w),
    .blink(blink_w),
    .red_on(red_pat_w)
  );

  // internal error wins and is steady; otherwise lowest-numbered cause wins
  function [2:0] flash_code;
    input [5:0] causes;
    begin
      if (causes[`DG_INTERNAL]) flash_code = `CODE_STEADY;
      else if (causes[`DG_OUT_A]) flash_code = 3'h1;
      else if (causes[`DG_OUT_B]) flash_code = 3'h2;
      else if (causes[`DG_CROSS]) flash_code = 3'h3;
      else if (causes[`DG_TEMP]) flash_code = 3'h4;
      else if (causes[`DG_ACTR]) flash_code = 3'h5;
      else flash_code = `CODE_NONE;
    end
  endfunction

  // fault state
  reg [5:0] fail_r;
  reg [39:0] wtimer_r;
  reg wexp_r;
  reg act_prev_r;
  wire warn_act = |warn_s;
  wire fail_act = |fail_r;
  wire [5:0] out_mask = 6'h07;

  // RULE10 reset bit falling edge
  wire rst_fall = ctrl_prev_r[`CTRL_ERR_RST] & ~ctrl_r[`CTRL_ERR_RST];
  // guard opened: actuator left range
  wire opened = act_prev_r & ~act_s;
  reg [5:0] clr_w;

  always @* begin
    // RULE10 only causes that have gone
    clr_w = ~fail_s & ~out_mask & {6{rst_fall | opened}};
    // RULE11 output faults only at release
    clr_w = clr_w | (~fail_s & out_mask & {6{opened}});
    code_w = flash_code(fail_act ? fail_r : warn_s);
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fail_r <= 6'h0;
      act_prev_r <= 1'b0;
      ctrl_prev_r <= `CTRL_RST_VAL;
    end else begin
      act_prev_r <= act_s;
      ctrl_prev_r <= ctrl_r;
      // RULE9 latch; new cause beats clear
      fail_r <= (fail_r & ~clr_w) | fail_s;
    end
  end

  // RULE7 shutdown timer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wtimer_r <= 40'h0;
      wexp_r <= 1'b0;
    end else if (!warn_act) begin
      // RULE8 clears, RULE20 restarts from zero
      wtimer_r <= 40'h0;
      wexp_r <= 1'b0;
    end else if (wtimer_r >= WARN_CYC - 40'h1) begin
      wexp_r <= 1'b1;
    end else begin
      wtimer_r <= wtimer_r + 40'h1;
    end
  end

  // output decisions
  wire enable_w = ready_s & act_s & inok_s & ~fail_act & ~wexp_r;
  wire any_fault = fail_act | warn_act;
  reg own_diag;

  always @* begin
    own_diag = 1'b0;
    if (ready_s & act_s) begin
      // RULE4 pulsed in limit area
      own_diag = limit_s ? blink_w : 1'b1;
    end
    // RULE6 fault forces low
    if (any_fault) begin
      own_diag = 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safety_out_a <= 1'b0;
      safety_out_b <= 1'b0;
      diag_out <= 1'b0;
      led_green <= 1'b0;
      led_yellow <= 1'b0;
      led_red <= 1'b0;
    end else begin
      // RULE12 hold state on link loss
      if (!comm_s || fail_act) begin
        // RULE1 RULE2 RULE9 outputs follow enable
        safety_out_a <= enable_w;
        safety_out_b <= enable_w;
      end
      // RULE13 series chain of diagnostics
      diag_out <= own_diag & chain_s;
      // RULE16 low diag with outputs on
      // RULE1 green when idle and ready
      led_green <= ready_s & ~act_s & ~any_fault;
      // RULE3 1Hz flash near limit
      led_yellow <= ready_s & act_s & ~any_fault & (~limit_s | blink_w);
      // RULE5 red cause code
      led_red <= any_fault & red_pat_w;
    end
  end

  // RULE14 status bytes refreshed each cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      resp_byte <= 8'h00;
      warn_byte <= 8'h00;
      err_byte <= 8'h00;
    end else begin
      // RULE17 one means present
      resp_byte <= 8'h00;
      resp_byte[`RSP_SAFE] <= safety_out_a & safety_out_b;
      resp_byte[`RSP_ACT] <= act_s;
      resp_byte[`RSP_INOK] <= inok_s;
      resp_byte[`RSP_LIMIT] <= act_s & limit_s;
      resp_byte[`RSP_WARN] <= any_fault;
      resp_byte[`RSP_ERR] <= fail_act | wexp_r;
      warn_byte <= {1'b0, comm_s, warn_s};
      err_byte <= {2'b00, fail_r};
    end
  end

  // ahb-lite: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h0;
      hrdata <= 32'h0;
    end else begin
      wr_pend_r <= req_w & hwrite;
      if (req_w) begin
        wr_addr_r <= haddr;
      end
      if (req_w & ~hwrite) begin
        case (haddr)
          `OFS_CTRL: hrdata <= {24'h0, ctrl_r};
          `OFS_CHAIN: hrdata <= {27'h0, chain_r};
          `OFS_RESP: hrdata <= {24'h0, resp_byte};
          `OFS_WARN: hrdata <= {24'h0, warn_byte};
          `OFS_ERR: hrdata <= {24'h0, err_byte};
          `OFS_STAT: hrdata <= {22'h0, wexp_r, fail_act, warn_act,
                                diag_out, safety_out_b, safety_out_a,
                                led_red, led_yellow, led_green, own_diag};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // RULE15 RULE18 request byte from controller
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `CTRL_RST_VAL;
      chain_r <= `CHAIN_RST_VAL;
    end else if (wr_pend_r) begin
      if (wr_addr_r == `OFS_CTRL) begin
        ctrl_r <= hwdata[7:0];
      end
      // RULE13 positions beyond the chain refused
      if (wr_addr_r == `OFS_CHAIN && hwdata[4:0] < 5'd`MAX_CHAIN) begin
        chain_r <= hwdata[4:0];
      end
    end
  end
endmodule // safety_diag
`default_nettype wire

// *** bench/chain_peer.sv ***
// downstream chained sensor feeding the diagnostic chain
`timescale 1ns/1ps
`default_nettype none
module chain_peer (
  // fault request from the bench
  input wire logic fault,
  // diagnostic level towards the block
  output logic serial_diag_in
);
  assign serial_diag_in = !fault;
endmodule // chain_peer
`default_nettype wire

// *** bench/safety_diag_checker.sv ***
// port assertions for the safety diagnostic block
`timescale 1ns/1ps
`default_nettype none
module safety_diag_checker #(
  parameter [39:0] WARN_CYC = 40'h32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // sensor pins
  input wire logic sensor_ready,
  input wire logic act_present,
  input wire logic act_limit,
  input wire logic inputs_ok,
  input wire logic comm_err,
  input wire logic serial_diag_in,
  input wire logic [5:0] warn_cause,
  input wire logic [5:0] fail_cause,
  // outputs
  input wire logic led_green,
  input wire logic led_yellow,
  input wire logic diag_out,
  input wire logic safety_out_a,
  input wire logic safety_out_b,
  input wire logic [7:0] err_byte
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic quiet;
  int warn_run_r;
  // no fault anywhere, so outputs follow the actuator alone
  assign quiet = sensor_ready && inputs_ok && !comm_err && serial_diag_in
    && fail_cause == 6'h00 && warn_cause == 6'h00 && err_byte == 8'h00;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      warn_run_r <= 0;
    else if (|warn_cause && !(|fail_cause) && !comm_err)
      warn_run_r <= warn_run_r + 1;
    else
      warn_run_r <= 0;
  end
  a_idle_green: assert property (
    (quiet && !act_present) [*4] |-> led_green && !diag_out
    && !safety_out_a && !safety_out_b) else $error("idle state wrong");
  a_act_yellow: assert property (
    (quiet && act_present && !act_limit) [*6] |-> led_yellow && diag_out
    && safety_out_a && safety_out_b) else $error("actuated state wrong");
  // failures need one more edge: the latch sits before the outputs
  a_fault_diag: assert property (
    (|fail_cause || |warn_cause) [*5] |-> !diag_out)
    else $error("diag high under fault");
  a_fail_drop: assert property (
    (|fail_cause) [*5] |-> !safety_out_a && !safety_out_b)
    else $error("outputs on under failure");
  a_fail_latch: assert property (
    (|fail_cause) [*5] |-> err_byte != 8'h00)
    else $error("failure not latched");
  a_comm_hold: assert property (
    (comm_err && fail_cause == 6'h00 && err_byte == 8'h00) [*5]
    |-> $stable(safety_out_a) && $stable(safety_out_b))
    else $error("outputs moved on link loss");
  a_warn_hold: assert property (
    warn_run_r == 4 && safety_out_a |-> safety_out_a [*8])
    else $error("warning dropped outputs early");
  a_warn_expire: assert property (
    warn_run_r == WARN_CYC + 8 |-> !safety_out_a && !safety_out_b)
    else $error("warning timer never expired");
  a_diag_chain: assert property (
    (!serial_diag_in) [*4] |-> !diag_out)
    else $error("chain level ignored");
endmodule // safety_diag_checker
bind safety_diag safety_diag_checker #(.WARN_CYC(WARN_CYC)) chk_i (
  .hclk, .hresetn, .sensor_ready, .act_present, .act_limit, .inputs_ok,
  .comm_err,
  .serial_diag_in, .warn_cause, .fail_cause, .led_green, .led_yellow,
  .diag_out, .safety_out_a, .safety_out_b, .err_byte);
`default_nettype wire

// *** bench/safety_diag_tb.sv ***
// self-checking bench for the safety diagnostic block
`include "safety_diag_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module safety_diag_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd;
  logic sensor_ready = 1, act_present = 0, act_limit = 0;
  logic inputs_ok = 1, comm_err = 0, peer_fault = 0;
  logic [5:0] warn_cause = 6'h00, fail_cause = 6'h00;
  wire hreadyout, hresp, led_green, led_yellow, led_red, diag_out;
  wire safety_out_a, safety_out_b, serial_diag_in;
  wire [31:0] hrdata;
  wire [7:0] resp_byte, warn_byte, err_byte;
  int n_fail = 0, total_checks = 0;
  always #2 hclk = ~hclk;
  chain_peer chain_peer_i (.fault(peer_fault), .serial_diag_in);
  // short counts keep the timers inside the run
  safety_diag #(.WARN_CYC(40'h32), .HALF_CYC(32'h4), .PULSE_CYC(32'h3),
    .PAUSE_CYC(32'hC)) safety_diag_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .sensor_ready, .act_present,
    .act_limit, .inputs_ok, .warn_cause, .fail_cause, .comm_err,
    .serial_diag_in, .led_green, .led_yellow, .led_red, .diag_out,
    .safety_out_a, .safety_out_b, .resp_byte, .warn_byte, .err_byte);
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // waits for hready, never longer than the bound
  task automatic wt;
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      n_fail++;
      summarize;
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w, logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1;
    wt;
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  // request byte: reset bit raised then dropped
  task automatic err_reset;
    bus(`OFS_CTRL, 1, 32'h80);
    bus(`OFS_CTRL, 1, 32'h00);
    cyc(6);
  endtask
  // red pulses of one group, found between two long pauses
  task automatic red_code(output int n);
    int low, k;
    n = 0;
    low = 0;
    k = 0;
    while (low < 8 && k < 200) begin
      @(posedge hclk);
      k++;
      low = led_red ? 0 : low + 1;
    end
    low = 0;
    while (low < 8 && k < 400) begin
      @(posedge hclk);
      k++;
      if (led_red && low > 0)
        n++;
      low = led_red ? 0 : low + 1;
    end
  endtask
  task automatic t_regs;
    cyc(6);
    chk("green", led_green, 32'h1);
    chk("outs", {diag_out, safety_out_a, safety_out_b}, 32'h0);
    bus(`OFS_RESP, 0, 32'h0);
    chk("resp", rd, 32'h10);
    chk("okay", hresp, 32'h0);
    bus(12'h100, 0, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(`OFS_CHAIN, 1, 32'h1E);
    bus(`OFS_CHAIN, 1, 32'h1F);
    bus(`OFS_CHAIN, 0, 32'h0);
    chk("chain", rd, 32'h1E);
    $display("regs done");
  endtask
  task automatic t_act;
    int ty, td;
    act_present <= 1;
    cyc(6);
    chk("yellow", led_yellow, 32'h1);
    chk("outs", {diag_out, safety_out_a, safety_out_b}, 32'h7);
    chk("resp", resp_byte, 32'h13);
    act_limit <= 1;
    cyc(6);
    ty = 0;
    td = 0;
    repeat (24) begin
      @(posedge hclk);
      if (led_yellow) ty++;
      if (diag_out) td++;
    end
    // half period of 4 cycles: 24 cycles hold three full periods
    chk("blink", ty, 32'hC);
    chk("pulse", td, 32'hC);
    chk("limit outs", {safety_out_a, safety_out_b}, 32'h3);
    chk("resp", resp_byte, 32'h33);
    act_limit <= 0;
    $display("act done");
  endtask
  task automatic t_warn;
    warn_cause <= 6'h08;
    cyc(7);
    chk("warn", {diag_out, safety_out_a, safety_out_b}, 32'h3);
    chk("wbyte", warn_byte, 32'h08);
    chk("resp", resp_byte, 32'h53);
    cyc(60);
    chk("expired", {safety_out_a, safety_out_b}, 32'h0);
    chk("resp expired", resp_byte, 32'hD2);
    warn_cause <= 6'h00;
    cyc(7);
    chk("cleared", {diag_out, safety_out_a}, 32'h3);
    warn_cause <= 6'h02;
    cyc(40);
    chk("restart", safety_out_a, 32'h1);
    warn_cause <= 6'h00;
    cyc(7);
    $display("warn done");
  endtask
  task automatic t_fail;
    int n;
    for (int i = 0; i < 6; i++) begin
      fail_cause <= 6'h01 << i;
      cyc(7);
      chk("fail outs", {safety_out_a, safety_out_b}, 32'h0);
      chk("ebyte", err_byte, 32'h01 << i);
      red_code(n);
      chk("code", n, i < 5 ? i + 1 : 0);
      if (i == 5)
        chk("steady", led_red, 32'h1);
      fail_cause <= 6'h00;
      act_present <= 0;
      cyc(7);
      act_present <= 1;
      cyc(7);
      chk("guard clear", err_byte, 32'h0);
    end
    fail_cause <= 6'h08;
    cyc(7);
    err_reset;
    chk("cause held", err_byte, 32'h08);
    fail_cause <= 6'h00;
    cyc(7);
    chk("latched", err_byte, 32'h08);
    err_reset;
    chk("reset clear", {err_byte, safety_out_a}, 32'h1);
    fail_cause <= 6'h01;
    cyc(7);
    fail_cause <= 6'h00;
    cyc(7);
    err_reset;
    chk("out fault kept", err_byte, 32'h01);
    act_present <= 0;
    cyc(7);
    act_present <= 1;
    cyc(7);
    $display("fail done");
  endtask
  task automatic t_link;
    comm_err <= 1;
    cyc(6);
    chk("comm bit", warn_byte, 32'h40);
    act_present <= 0;
    cyc(8);
    chk("frozen", {safety_out_a, safety_out_b}, 32'h3);
    comm_err <= 0;
    cyc(7);
    chk("released", safety_out_a, 32'h0);
    act_present <= 1;
    cyc(7);
    peer_fault <= 1;
    cyc(6);
    chk("chain diag", {diag_out, safety_out_a}, 32'h1);
    peer_fault <= 0;
    $display("link done");
  endtask
  initial begin
    cyc(20);
    hresetn <= 1;
    t_regs;
    t_act;
    t_warn;
    t_fail;
    t_link;
    summarize;
  end
endmodule // safety_diag_tb
`default_nettype wire
